// ==== rtl/pin_sync.sv ====
`timescale 1ns/1ps
// two-flop synchroniser for asynchronous pins
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinSync
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= pinIn;
      sync_ff <= meta_ff;
    end
  end

  assign pinSync = sync_ff;
endmodule

// ==== rtl/sysref_ctrl_pkg.sv ====
package sysref_ctrl_pkg;
  // register map, byte wide registers behind the serial control port
  localparam logic [15:0] ADDR_PW_DIV_LOW   = 16'h0400;
  localparam logic [15:0] ADDR_PW_DIV_HIGH  = 16'h0401;
  localparam logic [15:0] ADDR_REQ_CONFIG   = 16'h0402;
  localparam logic [15:0] ADDR_SRC_MODE_CFG = 16'h0403;
  localparam logic [15:0] ADDR_RX_CONFIG    = 16'h0404;

  // reset values
  localparam logic [7:0] RST_PW_DIV_LOW   = 8'h00;
  localparam logic [7:0] RST_PW_DIV_HIGH  = 8'h00;
  localparam logic [7:0] RST_REQ_CONFIG   = 8'h00;
  localparam logic [7:0] RST_SRC_MODE_CFG = 8'h00;
  localparam logic [7:0] RST_RX_CONFIG    = 8'h04;
  localparam logic [7:0] RX_CONFIG_MASK   = 8'h07;

  // request config fields
  localparam int REQ_METHOD_BIT  = 7;
  localparam int TRIG_HI         = 6;
  localparam int TRIG_LO         = 5;
  localparam int GEN_CLK_SEL_BIT = 4;
  localparam int RESAMP_SEL_BIT  = 3;
  localparam int TEST_HI         = 2;
  localparam int TEST_LO         = 1;
  localparam int GEN_RESET_BIT   = 0;

  // source / mode fields
  localparam int SRC_HI       = 7;
  localparam int SRC_LO       = 6;
  localparam int MODE_HI      = 5;
  localparam int MODE_LO      = 4;
  localparam int COUNT_HI     = 3;
  localparam int COUNT_LO     = 1;
  localparam int SW_REQ_BIT   = 0;

  // receiver fields
  localparam int RX_PD_CTRL_BIT = 2;
  localparam int RX_NEG_SEL_BIT = 1;
  localparam int RX_DIFF_BIT    = 0;

  // encodings
  localparam logic [1:0] TRIG_RISE   = 2'h2;
  localparam logic [1:0] TRIG_FALL   = 2'h3;
  localparam logic [1:0] MODE_NSHOT  = 2'h0;
  localparam logic [1:0] MODE_CONT   = 2'h1;
  localparam logic [1:0] SRC_EXT     = 2'h0;
  localparam logic [1:0] SRC_EXT_RS  = 2'h1;
  localparam logic [1:0] SRC_INT     = 2'h2;
  localparam logic [1:0] TEST_LOW    = 2'h0;
  localparam logic [1:0] TEST_HIGH   = 2'h1;

  // pin synchroniser lanes
  localparam int PIN_COUNT     = 5;
  localparam int PIN_REQ       = 0;
  localparam int PIN_EXT_PULSE = 1;
  localparam int PIN_FB_CLK    = 2;
  localparam int PIN_CLEAN_CLK = 3;
  localparam int PIN_DEV_CLK   = 4;

  typedef enum logic [1:0] {GEN_IDLE, GEN_ARMED, GEN_ACTIVE} gen_state_t;
endpackage

// ==== rtl/sysref_pattern_generator_control.sv ====
`timescale 1ns/1ps
module sysref_pattern_generator_control (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [15:0] regAddr,
  input  wire logic [7:0]  regWrData,
  output logic      [7:0]  regRdData,
  input  wire logic        pulseRequestPin,
  input  wire logic        alignmentPulseInput,
  input  wire logic        synthesisLoopFbClk,
  input  wire logic        cleanupLoopClk,
  input  wire logic        deviceClk,
  output logic             pulseOut,
  output logic             testOut,
  output logic             rxPosEn,
  output logic             rxNegEn,
  output logic             rxDiffEn
);
  // register state
  logic [7:0] divLow_ff, nxt_divLow;
  logic [7:0] divHigh_ff, nxt_divHigh;
  logic [7:0] reqCfg_ff, nxt_reqCfg;
  logic [7:0] srcCfg_ff, nxt_srcCfg;
  logic [7:0] rxCfg_ff, nxt_rxCfg;
  logic [7:0] rdData_ff, nxt_rdData;

  // generator state
  sysref_ctrl_pkg::gen_state_t state_ff, nxt_state;
  logic [15:0] kCnt_ff, nxt_kCnt;
  logic        divPhase_ff, nxt_divPhase;
  logic [3:0]  pulsesLeft_ff, nxt_pulsesLeft;
  logic        swReqPrev_ff, nxt_swReqPrev;
  logic        pinPrev_ff, nxt_pinPrev;
  logic        fbPrev_ff, cleanPrev_ff, devPrev_ff;
  logic        resampled_ff, nxt_resampled;

  // output flops
  logic pulseOut_ff, nxt_pulseOut;
  logic testOut_ff, nxt_testOut;
  logic rxPos_ff, rxNeg_ff, rxDiff_ff;
  logic nxt_rxPos, nxt_rxNeg, nxt_rxDiff;

  logic [sysref_ctrl_pkg::PIN_COUNT-1:0] pinsRaw;
  logic [sysref_ctrl_pkg::PIN_COUNT-1:0] pinsSync;

  logic [15:0] kEff;
  logic        genTick, wrap, divRise, divFall;
  logic        reqLevel, trigger, stopReq, burstDone;
  logic [1:0]  trigSel, mode, srcSel, testSel;
  logic        swReq, genReset;
  logic        fbRise, cleanRise, devRise, resampTick;

  // all foreign clocks and pins sampled into core_clk domain
  assign pinsRaw[sysref_ctrl_pkg::PIN_REQ]       = pulseRequestPin;
  assign pinsRaw[sysref_ctrl_pkg::PIN_EXT_PULSE] = alignmentPulseInput;
  assign pinsRaw[sysref_ctrl_pkg::PIN_FB_CLK]    = synthesisLoopFbClk;
  assign pinsRaw[sysref_ctrl_pkg::PIN_CLEAN_CLK] = cleanupLoopClk;
  assign pinsRaw[sysref_ctrl_pkg::PIN_DEV_CLK]   = deviceClk;

  pin_sync #(
    .WIDTH(sysref_ctrl_pkg::PIN_COUNT)
  ) u_pin_sync (
    .core_clk(core_clk),
    .sys_rst (sys_rst),
    .pinIn   (pinsRaw),
    .pinSync (pinsSync)
  );

  // field decode
  assign trigSel  = reqCfg_ff[sysref_ctrl_pkg::TRIG_HI:sysref_ctrl_pkg::TRIG_LO];
  assign testSel  = reqCfg_ff[sysref_ctrl_pkg::TEST_HI:sysref_ctrl_pkg::TEST_LO];
  assign genReset = reqCfg_ff[sysref_ctrl_pkg::GEN_RESET_BIT];
  assign mode     = srcCfg_ff[sysref_ctrl_pkg::MODE_HI:sysref_ctrl_pkg::MODE_LO];
  assign srcSel   = srcCfg_ff[sysref_ctrl_pkg::SRC_HI:sysref_ctrl_pkg::SRC_LO];
  assign swReq    = srcCfg_ff[sysref_ctrl_pkg::SW_REQ_BIT];

  // burst count code to pulse count; unlisted codes give one pulse
  function automatic logic [3:0] burstLen(input logic [2:0] code);
    unique case (code)
      3'h2:    burstLen = 4'h2;
      3'h3:    burstLen = 4'h4;
      3'h4:    burstLen = 4'h6;
      3'h5:    burstLen = 4'h8;
      default: burstLen = 4'h1;
    endcase
  endfunction

  // clock edges as one-cycle enables
  assign fbRise    = pinsSync[sysref_ctrl_pkg::PIN_FB_CLK] & ~fbPrev_ff;
  assign cleanRise = pinsSync[sysref_ctrl_pkg::PIN_CLEAN_CLK] & ~cleanPrev_ff;
  assign devRise   = pinsSync[sysref_ctrl_pkg::PIN_DEV_CLK] & ~devPrev_ff;
  assign genTick   = reqCfg_ff[sysref_ctrl_pkg::GEN_CLK_SEL_BIT] ? cleanRise : fbRise;
  assign resampTick = reqCfg_ff[sysref_ctrl_pkg::RESAMP_SEL_BIT] ? cleanRise : devRise;

  // width divider; zero treated as one so the divider never stalls
  assign kEff    = ({divHigh_ff, divLow_ff} == 16'h0000) ? 16'h0001
                                                          : {divHigh_ff, divLow_ff};
  assign wrap    = genTick && (kCnt_ff >= kEff - 16'h0001);
  assign divRise = wrap && !divPhase_ff;
  assign divFall = wrap && divPhase_ff;

  // request source and trigger qualification
  assign reqLevel = pinsSync[sysref_ctrl_pkg::PIN_REQ];
  always_comb begin
    trigger = 1'b0;
    stopReq = 1'b0;
    if (reqCfg_ff[sysref_ctrl_pkg::REQ_METHOD_BIT]) begin
      unique case (trigSel)
        sysref_ctrl_pkg::TRIG_RISE: trigger = reqLevel && !pinPrev_ff;
        sysref_ctrl_pkg::TRIG_FALL: trigger = !reqLevel && pinPrev_ff;
        default: begin
          trigger = reqLevel;
          stopReq = !reqLevel;
        end
      endcase
    end else begin
      trigger = swReq && !swReqPrev_ff;
      stopReq = !swReq;
    end
  end

  // pattern generator sequencing
  always_comb begin
    nxt_state      = state_ff;
    nxt_kCnt       = kCnt_ff;
    nxt_divPhase   = divPhase_ff;
    nxt_pulsesLeft = pulsesLeft_ff;
    burstDone      = 1'b0;
    if (genTick) begin
      nxt_kCnt = wrap ? 16'h0000 : kCnt_ff + 16'h0001;
      if (wrap) begin
        nxt_divPhase = !divPhase_ff;
      end
    end
    unique case (state_ff)
      sysref_ctrl_pkg::GEN_IDLE: begin
        if (trigger && (mode == sysref_ctrl_pkg::MODE_NSHOT
                        || mode == sysref_ctrl_pkg::MODE_CONT)) begin
          nxt_state      = sysref_ctrl_pkg::GEN_ARMED;
          nxt_pulsesLeft = burstLen(srcCfg_ff[sysref_ctrl_pkg::COUNT_HI:
                                              sysref_ctrl_pkg::COUNT_LO]);
        end
      end
      sysref_ctrl_pkg::GEN_ARMED: begin
        // align the first pulse to a divider rising phase
        if (divRise) begin
          nxt_state = sysref_ctrl_pkg::GEN_ACTIVE;
        end
      end
      sysref_ctrl_pkg::GEN_ACTIVE: begin
        // finish each pulse whole before stopping
        if (divFall) begin
          if (mode == sysref_ctrl_pkg::MODE_NSHOT) begin
            nxt_pulsesLeft = pulsesLeft_ff - 4'h1;
            if (pulsesLeft_ff == 4'h1) begin
              nxt_state = sysref_ctrl_pkg::GEN_IDLE;
              burstDone = 1'b1;
            end
          end else if (stopReq) begin
            nxt_state = sysref_ctrl_pkg::GEN_IDLE;
          end
        end
      end
    endcase
    // stop/invalid mode or generator reset abort at once
    if (genReset || !(mode == sysref_ctrl_pkg::MODE_NSHOT
                      || mode == sysref_ctrl_pkg::MODE_CONT)) begin
      nxt_state      = sysref_ctrl_pkg::GEN_IDLE;
      nxt_kCnt       = 16'h0000;
      nxt_divPhase   = 1'b0;
      nxt_pulsesLeft = 4'h0;
    end
    nxt_swReqPrev = swReq;
    nxt_pinPrev   = reqLevel;
  end

  // register writes; hardware self-clear loses to a software set
  always_comb begin
    nxt_divLow  = divLow_ff;
    nxt_divHigh = divHigh_ff;
    nxt_reqCfg  = reqCfg_ff;
    nxt_srcCfg  = srcCfg_ff;
    nxt_rxCfg   = rxCfg_ff;
    if (burstDone) begin
      nxt_srcCfg[sysref_ctrl_pkg::SW_REQ_BIT] = 1'b0;
    end
    if (regWrEn) begin
      unique case (regAddr)
        sysref_ctrl_pkg::ADDR_PW_DIV_LOW:   nxt_divLow  = regWrData;
        sysref_ctrl_pkg::ADDR_PW_DIV_HIGH:  nxt_divHigh = regWrData;
        sysref_ctrl_pkg::ADDR_REQ_CONFIG:   nxt_reqCfg  = regWrData;
        sysref_ctrl_pkg::ADDR_SRC_MODE_CFG: nxt_srcCfg  = regWrData;
        sysref_ctrl_pkg::ADDR_RX_CONFIG:
          nxt_rxCfg = regWrData & sysref_ctrl_pkg::RX_CONFIG_MASK;
        default: ;
      endcase
    end
  end

  // read mux, registered; unmapped addresses read zero
  always_comb begin
    nxt_rdData = rdData_ff;
    if (regRdEn) begin
      unique case (regAddr)
        sysref_ctrl_pkg::ADDR_PW_DIV_LOW:   nxt_rdData = divLow_ff;
        sysref_ctrl_pkg::ADDR_PW_DIV_HIGH:  nxt_rdData = divHigh_ff;
        sysref_ctrl_pkg::ADDR_REQ_CONFIG:   nxt_rdData = reqCfg_ff;
        sysref_ctrl_pkg::ADDR_SRC_MODE_CFG: nxt_rdData = srcCfg_ff;
        sysref_ctrl_pkg::ADDR_RX_CONFIG:    nxt_rdData = rxCfg_ff;
        default:                            nxt_rdData = 8'h00;
      endcase
    end
  end

  // outputs: source select, test mode and receiver enables
  always_comb begin
    nxt_resampled = resampTick ? pinsSync[sysref_ctrl_pkg::PIN_EXT_PULSE]
                               : resampled_ff;
    unique case (srcSel)
      sysref_ctrl_pkg::SRC_EXT:    nxt_pulseOut = pinsSync[sysref_ctrl_pkg::PIN_EXT_PULSE];
      sysref_ctrl_pkg::SRC_EXT_RS: nxt_pulseOut = resampled_ff;
      sysref_ctrl_pkg::SRC_INT:
        nxt_pulseOut = (state_ff == sysref_ctrl_pkg::GEN_ACTIVE) && divPhase_ff;
      default:                     nxt_pulseOut = 1'b0;
    endcase
    unique case (testSel)
      sysref_ctrl_pkg::TEST_LOW:  nxt_testOut = 1'b0;
      sysref_ctrl_pkg::TEST_HIGH: nxt_testOut = 1'b1;
      default:                    nxt_testOut = divPhase_ff;
    endcase
    if (rxCfg_ff[sysref_ctrl_pkg::RX_DIFF_BIT]) begin
      nxt_rxDiff = 1'b1;
      nxt_rxPos  = 1'b0;
      nxt_rxNeg  = 1'b0;
    end else begin
      nxt_rxDiff = 1'b0;
      if (!rxCfg_ff[sysref_ctrl_pkg::RX_PD_CTRL_BIT]) begin
        nxt_rxPos = 1'b1;
        nxt_rxNeg = 1'b1;
      end else begin
        nxt_rxNeg = rxCfg_ff[sysref_ctrl_pkg::RX_NEG_SEL_BIT];
        nxt_rxPos = !rxCfg_ff[sysref_ctrl_pkg::RX_NEG_SEL_BIT];
      end
    end
  end

  // all state registered here
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      divLow_ff     <= sysref_ctrl_pkg::RST_PW_DIV_LOW;
      divHigh_ff    <= sysref_ctrl_pkg::RST_PW_DIV_HIGH;
      reqCfg_ff     <= sysref_ctrl_pkg::RST_REQ_CONFIG;
      srcCfg_ff     <= sysref_ctrl_pkg::RST_SRC_MODE_CFG;
      rxCfg_ff      <= sysref_ctrl_pkg::RST_RX_CONFIG;
      rdData_ff     <= 8'h00;
      state_ff      <= sysref_ctrl_pkg::GEN_IDLE;
      kCnt_ff       <= 16'h0000;
      divPhase_ff   <= 1'b0;
      pulsesLeft_ff <= 4'h0;
      swReqPrev_ff  <= 1'b0;
      pinPrev_ff    <= 1'b0;
      fbPrev_ff     <= 1'b0;
      cleanPrev_ff  <= 1'b0;
      devPrev_ff    <= 1'b0;
      resampled_ff  <= 1'b0;
      pulseOut_ff   <= 1'b0;
      testOut_ff    <= 1'b0;
      rxPos_ff      <= 1'b1;
      rxNeg_ff      <= 1'b0;
      rxDiff_ff     <= 1'b0;
    end else begin
      divLow_ff     <= nxt_divLow;
      divHigh_ff    <= nxt_divHigh;
      reqCfg_ff     <= nxt_reqCfg;
      srcCfg_ff     <= nxt_srcCfg;
      rxCfg_ff      <= nxt_rxCfg;
      rdData_ff     <= nxt_rdData;
      state_ff      <= nxt_state;
      kCnt_ff       <= nxt_kCnt;
      divPhase_ff   <= nxt_divPhase;
      pulsesLeft_ff <= nxt_pulsesLeft;
      swReqPrev_ff  <= nxt_swReqPrev;
      pinPrev_ff    <= nxt_pinPrev;
      fbPrev_ff     <= pinsSync[sysref_ctrl_pkg::PIN_FB_CLK];
      cleanPrev_ff  <= pinsSync[sysref_ctrl_pkg::PIN_CLEAN_CLK];
      devPrev_ff    <= pinsSync[sysref_ctrl_pkg::PIN_DEV_CLK];
      resampled_ff  <= nxt_resampled;
      pulseOut_ff   <= nxt_pulseOut;
      testOut_ff    <= nxt_testOut;
      rxPos_ff      <= nxt_rxPos;
      rxNeg_ff      <= nxt_rxNeg;
      rxDiff_ff     <= nxt_rxDiff;
    end
  end

  assign regRdData = rdData_ff;
  assign pulseOut  = pulseOut_ff;
  assign testOut   = testOut_ff;
  assign rxPosEn   = rxPos_ff;
  assign rxNegEn   = rxNeg_ff;
  assign rxDiffEn  = rxDiff_ff;
endmodule

// ==== test/sysref_ctrl_properties.sv ====
`timescale 1ns/1ps
module sysref_ctrl_checker (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [15:0] regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic [7:0]  regRdData,
  input wire logic        alignmentPulseInput,
  input wire logic        pulseOut,
  input wire logic        testOut,
  input wire logic        rxPosEn,
  input wire logic        rxNegEn,
  input wire logic        rxDiffEn
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [1:0] srcSeen_ff;
  logic [1:0] nxt_srcSeen;
  wire logic  rxWr = regWrEn && regAddr == 16'h0404;
  // shadow of the source field, so pulse checks know what drives the output
  always_comb begin
    nxt_srcSeen = srcSeen_ff;
    if (regWrEn && regAddr == 16'h0403) begin
      nxt_srcSeen = regWrData[7:6];
    end
  end
  always_ff @(posedge core_clk) begin
    srcSeen_ff <= sys_rst ? 2'h0 : nxt_srcSeen;
  end
  diff_mode_on_a: assert property (rxWr && regWrData[0] |=> ##1 rxDiffEn)
    else $error("differential receiver not enabled");
  rx_exclusive_a: assert property (rxDiffEn |-> !rxPosEn && !rxNegEn)
    else $error("single ended receiver on in differential mode");
  rx_both_on_a: assert property (rxWr && regWrData[2:0] == 3'h0 |=> ##1 rxPosEn && rxNegEn)
    else $error("receivers not both enabled");
  neg_select_a: assert property (rxWr && regWrData[2:0] == 3'h6 |=> ##1 rxNegEn && !rxPosEn)
    else $error("negative receiver not selected");
  test_level_a: assert property (regWrEn && regAddr == 16'h0402 && !regWrData[2]
    |=> ##1 testOut == $past(regWrData[1], 2))
    else $error("test output level wrong");
  width_readback_a: assert property (regWrEn && regAddr == 16'h0400 ##1 !regWrEn
    ##1 regRdEn && !regWrEn && regAddr == 16'h0400 |=> regRdData == $past(regWrData, 3))
    else $error("low divider byte read back wrong");
  unmapped_zero_a: assert property (regRdEn && !(regAddr inside {[16'h0400:16'h0404]})
    |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  gen_reset_idle_a: assert property (regWrEn && regAddr == 16'h0402 && regWrData[0]
    && srcSeen_ff == 2'h2 |-> ##3 !pulseOut [*4])
    else $error("pulse during generator reset");
  ext_pass_a: assert property ($rose(alignmentPulseInput) && srcSeen_ff == 2'h0
    |-> ##[1:5] pulseOut)
    else $error("external pulse not passed");
  burst_seen_c: cover property ($rose(pulseOut) && srcSeen_ff == 2'h2);
  diff_seen_c: cover property (rxDiffEn);
  test_high_c: cover property (testOut);
endmodule
bind sysref_pattern_generator_control sysref_ctrl_checker i_sysref_ctrl_checker (
  .core_clk(core_clk), .sys_rst(sys_rst), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
  .alignmentPulseInput(alignmentPulseInput), .pulseOut(pulseOut), .testOut(testOut),
  .rxPosEn(rxPosEn), .rxNegEn(rxNegEn), .rxDiffEn(rxDiffEn)
);

// ==== test/sysref_far_side_model.sv ====
`timescale 1ns/1ps
// reference clocks and external pulse source beside the block
module sysref_far_side_model #(
  parameter int FB_DIV    = 8,
  parameter int CLEAN_DIV = 12,
  parameter int DEV_DIV   = 6
) (
  input  wire logic core_clk,
  input  wire logic extReq,
  output logic      synthesisLoopFbClk,
  output logic      cleanupLoopClk,
  output logic      deviceClk,
  output logic      alignmentPulseInput
);
  int tick = 0;
  // clocks locked to core_clk so tick spacing is exact; width checks stay tight
  always @(posedge core_clk) begin
    tick <= tick + 1;
  end
  assign synthesisLoopFbClk = (tick % FB_DIV) < FB_DIV / 2;
  assign cleanupLoopClk = (tick % CLEAN_DIV) < CLEAN_DIV / 2;
  assign deviceClk = (tick % DEV_DIV) < DEV_DIV / 2;
  assign alignmentPulseInput = extReq;
endmodule

// ==== test/test_sysref_pattern_generator_control.sv ====
`timescale 1ns/1ps
module test_sysref_pattern_generator_control;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        regWrEn = 1'b0;
  logic        regRdEn = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0]  regWrData = 8'h00;
  logic        pulseRequestPin = 1'b0;
  logic        extReq = 1'b0;
  logic [7:0]  regRdData;
  logic        alignmentPulseInput;
  logic        synthesisLoopFbClk;
  logic        cleanupLoopClk;
  logic        deviceClk;
  logic        pulseOut;
  logic        testOut;
  logic        rxPosEn;
  logic        rxNegEn;
  logic        rxDiffEn;
  logic [7:0]  v;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          seed = 35064;
  int          mdl [5] = '{0, 0, 0, 0, 4};
  int          nShot [8] = '{1, 1, 2, 4, 6, 8, 1, 1};
  logic [7:0]  trig [3] = '{8'h80, 8'hc0, 8'he0};
  logic [1:0]  expPin [3] = '{2'h2, 2'h2, 2'h1};
  logic [15:0] ext [4] = '{16'h0000, 16'h0040, 16'h0840, 16'h00c0};
  int          widths [$];
  int          per;
  int          k;
  int          a0;

  sysref_pattern_generator_control i_sysref_pattern_generator_control (
    .core_clk(core_clk), .sys_rst(sys_rst), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .pulseRequestPin(pulseRequestPin), .alignmentPulseInput(alignmentPulseInput),
    .synthesisLoopFbClk(synthesisLoopFbClk), .cleanupLoopClk(cleanupLoopClk),
    .deviceClk(deviceClk), .pulseOut(pulseOut), .testOut(testOut),
    .rxPosEn(rxPosEn), .rxNegEn(rxNegEn), .rxDiffEn(rxDiffEn));
  sysref_far_side_model i_sysref_far_side_model (
    .core_clk(core_clk), .extReq(extReq), .synthesisLoopFbClk(synthesisLoopFbClk),
    .cleanupLoopClk(cleanupLoopClk), .deviceClk(deviceClk),
    .alignmentPulseInput(alignmentPulseInput));

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic conclude();
    $display("mismatches %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // one access, then an idle cycle so strobes never toggle twice in a step
  task automatic bus(logic w, logic [15:0] a, logic [7:0] d);
    regWrEn = w;
    regRdEn = !w;
    regAddr = a;
    regWrData = d;
    step(1);
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    step(1);
    if (w && a inside {[16'h0400:16'h0404]}) begin
      mdl[a - 16'h0400] = d;
    end
  endtask

  task automatic rdc(logic [15:0] a);
    bus(1'b0, a, 8'h00);
    chk(regRdData, (a inside {[16'h0400:16'h0404]}) ? 16'(mdl[a - 16'h0400]
      & (a == 16'h0404 ? 8'h07 : 8'hff)) : 16'h0000);
  endtask

  // record every completed high run of a signal
  task automatic watch(ref logic s, input int lim);
    int run;
    run = 0;
    widths.delete();
    repeat (lim) begin
      step(1);
      if (s === 1'b1) begin
        run++;
      end else if (run > 0) begin
        widths.push_back(run);
        run = 0;
      end
    end
  endtask

  initial begin
    #2400000;
    error_cnt++;
    conclude();
  end

  initial begin
    step(8);
    sys_rst = 1'b0;
    // reset values and unmapped edges, then random divider bytes read back
    for (int p = 0; p < 2; p++) begin
      for (int a = 16'h03ff; a <= 16'h0405; a++) begin
        rdc(16'(a));
      end
      k = $random(seed);
      bus(1'b1, 16'h0400, k[7:0]);
      rdc(16'h0400);
      bus(1'b1, 16'h0401, k[15:8]);
      bus(1'b1, 16'h0404, 8'hff);
    end
    for (int i = 0; i < 8; i++) begin
      v = 8'(i);
      bus(1'b1, 16'h0404, v);
      chk({rxDiffEn, rxNegEn, rxPosEn}, v[0] ? 3'h4 : {1'b0, ~v[2] | v[1], ~v[2] | ~v[1]});
    end
    // test output: forced levels, then the divider phase with a width of one tick
    bus(1'b1, 16'h0400, 8'h01);
    bus(1'b1, 16'h0401, 8'h00);
    bus(1'b1, 16'h0402, 8'h02);
    chk(testOut, 1'b1);
    bus(1'b1, 16'h0402, 8'h00);
    chk(testOut, 1'b0);
    bus(1'b1, 16'h0402, 8'h04);
    watch(testOut, 60);
    chk(16'(widths[1]), 16'd8);
    // every burst code; divider 0 is the awkward case and acts as 1
    for (int c = 0; c < 8; c++) begin
      k = $unsigned($random(seed)) % 4;
      per = c[0] ? 12 : 8;
      bus(1'b1, 16'h0400, 8'(k));
      k = (k == 0) ? 1 : k;
      bus(1'b1, 16'h0402, {3'h0, c[0], 4'h0});
      bus(1'b1, 16'h0403, 8'h80 | 8'(c << 1));
      fork
        bus(1'b1, 16'h0403, 8'h81 | 8'(c << 1));
        watch(pulseOut, (2 * k * nShot[c] + 4) * per);
      join
      chk(16'(widths.size()), 16'(nShot[c]));
      foreach (widths[i]) chk(16'(widths[i]), 16'(k * per));
      mdl[3] = mdl[3] - 1;
      rdc(16'h0403);
    end
    // continuous holds the request bit and stops once it is cleared
    bus(1'b1, 16'h0403, 8'h90);
    fork
      bus(1'b1, 16'h0403, 8'h91);
      watch(pulseOut, 200);
    join
    chk(16'(widths.size() > 1), 16'd1);
    rdc(16'h0403);
    bus(1'b1, 16'h0403, 8'h90);
    watch(pulseOut, 100);
    watch(pulseOut, 100);
    chk(16'(widths.size()), 16'd0);
    // generator reset in mid-pattern, then stop and invalid modes
    fork
      bus(1'b1, 16'h0403, 8'h91);
      watch(pulseOut, 40);
    join
    bus(1'b1, 16'h0402, 8'h11);
    step(4);
    watch(pulseOut, 100);
    chk(16'(widths.size()), 16'd0);
    chk(pulseOut, 1'b0);
    bus(1'b1, 16'h0403, 8'h90);
    bus(1'b1, 16'h0402, 8'h10);
    for (int m = 2; m < 4; m++) begin
      fork
        bus(1'b1, 16'h0403, 8'h83 | 8'(m << 4));
        watch(pulseOut, 100);
      join
      chk(16'(widths.size()), 16'd0);
      bus(1'b1, 16'h0403, 8'h82);
    end
    // pin requests: level, rising edge and falling edge
    foreach (trig[i]) begin
      bus(1'b1, 16'h0402, trig[i]);
      pulseRequestPin = 1'b1;
      // long enough for sync, a full divider period of alignment and one pulse
      watch(pulseOut, 100);
      a0 = widths.size();
      pulseRequestPin = 1'b0;
      watch(pulseOut, 100);
      chk({a0 > 0, i > 0 && widths.size() > 0}, expPin[i]);
    end
    // external pulse direct, resampled on either clock, or blocked
    foreach (ext[i]) begin
      bus(1'b1, 16'h0402, ext[i][15:8]);
      bus(1'b1, 16'h0403, ext[i][7:0]);
      extReq = 1'b1;
      step(20);
      chk(pulseOut, i < 3);
      extReq = 1'b0;
      step(20);
      chk(pulseOut, 1'b0);
    end
    conclude();
  end
endmodule
